// ==== hia_defines.vh ====
// register offsets, field positions and reset values for the hub interrupt aggregator
//
// Function
// - gather four receive-port and two transmit-port sources into top control/status
// - status bits latch on their condition whatever the enable holds, except gpio and sensor edge flags, which need their enable or mask bit
// - pin low only when status, its enable and global enable are all set
// - with global enable clear, top status still reports, pin stays high
// - top status: 7 global, 6 reserved, 5:4 transmit ports, 3:0 receive ports
// - top control: 7 pin enable, 5:4 transmit, 3:0 receive port enables
// - per port two enable registers and two mirrored read-only status registers
// - reading port state or transmit-side state clears; mirrored reads do not
// - low flags: len change, count change, buffer, tx-side, parity, pass, lock
// - high flags: gpio, sensor change, encoding error, sequence error, checksum error
// - first state: port number, checksum, lock change, seq, parity, pass, lock
// - second state: len unstable, len change, enc, buffer, tx-side, freq, no clock, count
// - per-port registers banked by the port select register written first
// - enabled forward gpio rising/falling edges raise flags, read of flags clears them
// - each port holds 32-bit sensor state readable as four bytes
// - only sensor byte 0 bits interrupt, rise and fall separately masked
// - masked-in edges latch in rise/fall flags, masked-out flags read zero
// - any sensor rise or fall flag sets the sensor change flag
`ifndef HIA_DEFINES_VH
`define HIA_DEFINES_VH

// ----------------------------------------
// offsets
// ----------------------------------------
`define HIA_ADDR_TOP_CTRL 8'h23
`define HIA_ADDR_TOP_FLAGS 8'h24
`define HIA_ADDR_PORT_SEL 8'h4C
`define HIA_ADDR_STATE_ONE 8'h4D
`define HIA_ADDR_STATE_TWO 8'h4E
`define HIA_ADDR_EN_HIGH 8'hD8
`define HIA_ADDR_EN_LOW 8'hD9
`define HIA_ADDR_FL_HIGH 8'hDA
`define HIA_ADDR_FL_LOW 8'hDB
`define HIA_ADDR_TX_SIDE 8'hE0
`define HIA_ADDR_GPIO_EN 8'hE1
`define HIA_ADDR_GPIO_FL 8'hE2
`define HIA_ADDR_SEN_B0 8'hE4
`define HIA_ADDR_SEN_B1 8'hE5
`define HIA_ADDR_SEN_B2 8'hE6
`define HIA_ADDR_SEN_B3 8'hE7
`define HIA_ADDR_RISE_MASK 8'hE8
`define HIA_ADDR_FALL_MASK 8'hE9
`define HIA_ADDR_RISE_FL 8'hEA
`define HIA_ADDR_FALL_FL 8'hEB

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define HIA_TOP_GLOBAL_BIT 7
`define HIA_SEL_RD_LSB 4
`define HIA_TOP_CTRL_RST 8'h00
`define HIA_PORT_SEL_RST 8'h01
`define HIA_EN_RST 8'h00

`endif

// ==== hia_host.sv ====
// host model driving the register port
`timescale 1ns/100ps
module hia_host (
  input wire core_clk,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle strobes; banked writes use whatever port select is in place
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
  end
  endtask
endmodule

// ==== hia_sticky.v ====
// sticky flag bank: set wins over clear, masked-out bits forced to zero
`timescale 1ns/100ps
module hia_sticky #(
  parameter W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  input wire [W-1:0] mask,
  output wire [W-1:0] q
);

  reg [W-1:0] flag_reg;
  wire [W-1:0] flag_next;

  // set after clear so an event in the read cycle survives
  assign flag_next = ((flag_reg & ~clr) | set) & mask;
  assign q = flag_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_reg <= {W{1'b0}};
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

endmodule

// ==== hia_top.v ====
// interrupt aggregation for four receive ports and two transmit ports
`timescale 1ns/100ps
`include "hia_defines.vh"
module hia_top #(
  parameter NPORT = 4
) (
  input wire core_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire [3:0] rx_lock,
  input wire [3:0] rx_pass,
  input wire [3:0] rx_crc_err,
  input wire [3:0] rx_seq_err,
  input wire [3:0] rx_par_err,
  input wire [3:0] rx_enc_err,
  input wire [3:0] rx_buf_err,
  input wire [3:0] rx_len_unstable,
  input wire [3:0] rx_len_chg,
  input wire [3:0] rx_cnt_chg,
  input wire [3:0] rx_freq_stable,
  input wire [3:0] rx_no_clk,
  input wire [3:0] rx_tx_side_err,
  input wire [15:0] fwd_gpio,
  input wire [127:0] sensor_state,
  input wire tx0_irq_flag,
  input wire tx1_irq_flag,
  output wire irq_out_n
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_sync1_reg;
  reg rst_sync2_reg;
  wire rst_n;

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rst_n = rst_sync2_reg;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg [7:0] irq_top_control_reg;
  reg [7:0] port_select_reg;
  reg [7:0] en_high_reg [0:3];
  reg [7:0] en_low_reg [0:3];
  reg [7:0] gpio_en_reg [0:3];
  reg [7:0] rise_mask_reg [0:3];
  reg [7:0] fall_mask_reg [0:3];
  wire [1:0] rd_port;
  integer i;

  // reads follow the selected port, writes go to every port whose bit is set
  assign rd_port = port_select_reg[`HIA_SEL_RD_LSB +: 2];

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_top_control_reg <= `HIA_TOP_CTRL_RST;
      port_select_reg <= `HIA_PORT_SEL_RST;
      for (i = 0; i < 4; i = i + 1)
      begin
        en_high_reg[i] <= `HIA_EN_RST;
        en_low_reg[i] <= `HIA_EN_RST;
        gpio_en_reg[i] <= `HIA_EN_RST;
        rise_mask_reg[i] <= `HIA_EN_RST;
        fall_mask_reg[i] <= `HIA_EN_RST;
      end
    end
    else if (reg_wr)
    begin
      if (reg_addr == `HIA_ADDR_TOP_CTRL)
      begin
        irq_top_control_reg <= reg_wdata & 8'hBF;
      end
      if (reg_addr == `HIA_ADDR_PORT_SEL)
      begin
        port_select_reg <= reg_wdata & 8'h3F;
      end
      for (i = 0; i < 4; i = i + 1)
      begin
        if (port_select_reg[i])
        begin
          case (reg_addr)
            `HIA_ADDR_EN_HIGH: en_high_reg[i] <= reg_wdata & 8'h1F;
            `HIA_ADDR_EN_LOW: en_low_reg[i] <= reg_wdata & 8'h7F;
            `HIA_ADDR_GPIO_EN: gpio_en_reg[i] <= reg_wdata;
            `HIA_ADDR_RISE_MASK: rise_mask_reg[i] <= reg_wdata;
            `HIA_ADDR_FALL_MASK: fall_mask_reg[i] <= reg_wdata;
            default: en_high_reg[i] <= en_high_reg[i];
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // previous values for edge detection
  // ----------------------------------------
  reg [3:0] lock_prev_reg;
  reg [3:0] pass_prev_reg;
  reg [15:0] gpio_prev_reg;
  reg [31:0] sen_prev_reg;
  wire [31:0] sen_byte0;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_prev_reg <= 4'h0;
      pass_prev_reg <= 4'h0;
      gpio_prev_reg <= 16'h0000;
      sen_prev_reg <= 32'h00000000;
    end
    else
    begin
      lock_prev_reg <= rx_lock;
      pass_prev_reg <= rx_pass;
      gpio_prev_reg <= fwd_gpio;
      sen_prev_reg <= sen_byte0;
    end
  end

  // ----------------------------------------
  // per-port flags
  // ----------------------------------------
  wire rd_one;
  wire rd_two;
  wire rd_txs;
  wire rd_gpio;
  wire rd_rise;
  wire rd_fall;
  wire [31:0] st1_all;
  wire [31:0] st2_all;
  wire [31:0] txs_all;
  wire [31:0] gpio_fl_all;
  wire [31:0] rise_fl_all;
  wire [31:0] fall_fl_all;
  wire [31:0] fl_hi_all;
  wire [31:0] fl_lo_all;
  wire [3:0] port_irq;

  // only the state registers and the clear-on-read flag registers clear
  assign rd_one = reg_rd && (reg_addr == `HIA_ADDR_STATE_ONE);
  assign rd_two = reg_rd && (reg_addr == `HIA_ADDR_STATE_TWO);
  assign rd_txs = reg_rd && (reg_addr == `HIA_ADDR_TX_SIDE);
  assign rd_gpio = reg_rd && (reg_addr == `HIA_ADDR_GPIO_FL);
  assign rd_rise = reg_rd && (reg_addr == `HIA_ADDR_RISE_FL);
  assign rd_fall = reg_rd && (reg_addr == `HIA_ADDR_FALL_FL);

  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1)
    begin : g_port
      localparam [1:0] PNUM = p;
      wire [4:0] s1_q;
      wire [4:0] s2_q;
      wire [4:0] s2_clr;
      wire [7:0] gpio_q;
      wire [7:0] rise_q;
      wire [7:0] fall_q;
      wire [3:0] g_now;
      wire [3:0] g_old;
      wire [7:0] s_now;
      wire [7:0] s_old;
      wire [7:0] fl_lo;
      wire [7:0] fl_hi;

      wire sel = (rd_port == PNUM);
      assign g_now = fwd_gpio[4*p +: 4];
      assign g_old = gpio_prev_reg[4*p +: 4];
      assign sen_byte0[8*p +: 8] = sensor_state[32*p +: 8];
      assign s_now = sen_byte0[8*p +: 8];
      assign s_old = sen_prev_reg[8*p +: 8];

      // {checksum, lock change, sequence, parity, pass change}; no enable gating
      hia_sticky #(.W(5)) u_s1 (
        .clk(core_clk),
        .rst_n(rst_n),
        .set({rx_crc_err[p], rx_lock[p] ^ lock_prev_reg[p], rx_seq_err[p],
              rx_par_err[p], rx_pass[p] ^ pass_prev_reg[p]}),
        .clr({5{rd_one & sel}}),
        .mask(5'h1F),
        .q(s1_q)
      );

      // {length change, encoding, buffer, count change, tx-side error}
      assign s2_clr = {{4{rd_two & sel}}, (rd_two | rd_txs) & sel};
      hia_sticky #(.W(5)) u_s2 (
        .clk(core_clk),
        .rst_n(rst_n),
        .set({rx_len_chg[p], rx_enc_err[p], rx_buf_err[p], rx_cnt_chg[p],
              rx_tx_side_err[p]}),
        .clr(s2_clr),
        .mask(5'h1F),
        .q(s2_q)
      );

      // low nibble rising, high nibble falling
      hia_sticky #(.W(8)) u_gpio (
        .clk(core_clk),
        .rst_n(rst_n),
        .set({~g_now & g_old, g_now & ~g_old}),
        .clr({8{rd_gpio & sel}}),
        .mask(gpio_en_reg[p]),
        .q(gpio_q)
      );

      hia_sticky #(.W(8)) u_rise (
        .clk(core_clk),
        .rst_n(rst_n),
        .set(s_now & ~s_old),
        .clr({8{rd_rise & sel}}),
        .mask(rise_mask_reg[p]),
        .q(rise_q)
      );

      hia_sticky #(.W(8)) u_fall (
        .clk(core_clk),
        .rst_n(rst_n),
        .set(~s_now & s_old),
        .clr({8{rd_fall & sel}}),
        .mask(fall_mask_reg[p]),
        .q(fall_q)
      );

      // mirrors of the state bits, reading these clears nothing
      assign fl_lo = {1'b0, s2_q[4], s2_q[1], s2_q[2], s2_q[0], s1_q[1], s1_q[0], s1_q[3]};
      assign fl_hi = {3'b000, |gpio_q, |{rise_q, fall_q}, s2_q[3], s1_q[2], s1_q[4]};

      assign st1_all[8*p +: 8] = {PNUM, s1_q[4], s1_q[3], s1_q[2], s1_q[1], rx_pass[p], rx_lock[p]};
      assign st2_all[8*p +: 8] = {rx_len_unstable[p], s2_q[4], s2_q[3], s2_q[2], s2_q[0],
                                  rx_freq_stable[p], rx_no_clk[p], s2_q[1]};
      assign txs_all[8*p +: 8] = {7'h00, s2_q[0]};
      assign gpio_fl_all[8*p +: 8] = gpio_q;
      assign rise_fl_all[8*p +: 8] = rise_q;
      assign fall_fl_all[8*p +: 8] = fall_q;
      assign fl_hi_all[8*p +: 8] = fl_hi;
      assign fl_lo_all[8*p +: 8] = fl_lo;

      // enable decides only whether a flag counts toward the port request
      assign port_irq[p] = |(fl_lo & en_low_reg[p]) | |(fl_hi & en_high_reg[p]);
    end
  endgenerate

  // ----------------------------------------
  // top-level aggregation
  // ----------------------------------------
  wire [5:0] src_flags;
  wire global_ind;
  wire [7:0] irq_top_flags;
  reg irq_out_n_reg;

  assign src_flags = {tx1_irq_flag, tx0_irq_flag, port_irq};
  // reported even with the pin enable clear
  assign global_ind = |(src_flags & irq_top_control_reg[5:0]);
  assign irq_top_flags = {global_ind, 1'b0, src_flags};

  // registered so the pin never glitches while flags settle
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_out_n_reg <= 1'b1;
    end
    else
    begin
      irq_out_n_reg <= ~(global_ind & irq_top_control_reg[`HIA_TOP_GLOBAL_BIT]);
    end
  end

  assign irq_out_n = irq_out_n_reg;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [7:0] rd_mux;
  reg [7:0] reg_rdata_reg;

  always @*
  begin
    case (reg_addr)
      `HIA_ADDR_TOP_CTRL: rd_mux = irq_top_control_reg;
      `HIA_ADDR_TOP_FLAGS: rd_mux = irq_top_flags;
      `HIA_ADDR_PORT_SEL: rd_mux = port_select_reg;
      `HIA_ADDR_STATE_ONE: rd_mux = st1_all[8*rd_port +: 8];
      `HIA_ADDR_STATE_TWO: rd_mux = st2_all[8*rd_port +: 8];
      `HIA_ADDR_EN_HIGH: rd_mux = en_high_reg[rd_port];
      `HIA_ADDR_EN_LOW: rd_mux = en_low_reg[rd_port];
      `HIA_ADDR_FL_HIGH: rd_mux = fl_hi_all[8*rd_port +: 8];
      `HIA_ADDR_FL_LOW: rd_mux = fl_lo_all[8*rd_port +: 8];
      `HIA_ADDR_TX_SIDE: rd_mux = txs_all[8*rd_port +: 8];
      `HIA_ADDR_GPIO_EN: rd_mux = gpio_en_reg[rd_port];
      `HIA_ADDR_GPIO_FL: rd_mux = gpio_fl_all[8*rd_port +: 8];
      `HIA_ADDR_SEN_B0: rd_mux = sensor_state[32*rd_port +: 8];
      `HIA_ADDR_SEN_B1: rd_mux = sensor_state[32*rd_port + 8 +: 8];
      `HIA_ADDR_SEN_B2: rd_mux = sensor_state[32*rd_port + 16 +: 8];
      `HIA_ADDR_SEN_B3: rd_mux = sensor_state[32*rd_port + 24 +: 8];
      `HIA_ADDR_RISE_MASK: rd_mux = rise_mask_reg[rd_port];
      `HIA_ADDR_FALL_MASK: rd_mux = fall_mask_reg[rd_port];
      `HIA_ADDR_RISE_FL: rd_mux = rise_fl_all[8*rd_port +: 8];
      `HIA_ADDR_FALL_FL: rd_mux = fall_fl_all[8*rd_port +: 8];
      default: rd_mux = 8'h00;
    endcase
  end

  // data captured before the clear of the same read lands
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_reg <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata = reg_rdata_reg;

endmodule

// ==== hia_top_sva.sv ====
// port-level assertions for the hub interrupt aggregator
`timescale 1ns/100ps
module hia_top_sva (
  input wire core_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire tx0_irq_flag,
  input wire tx1_irq_flag,
  input wire irq_out_n
);
  // ----------------------------------------
  // shadows rebuilt from the port
  // ----------------------------------------
  // avoids reaching into the design; writes are the only source of change
  reg [7:0] ctl_reg;
  reg [1:0] sel_reg;
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
      ctl_reg <= 8'h00;
    else if (reg_wr && reg_addr == 8'h23)
      ctl_reg <= reg_wdata & 8'hBF;
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
      sel_reg <= 2'b00;
    else if (reg_wr && reg_addr == 8'h4C)
      sel_reg <= reg_wdata[5:4];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_pin_gated: assert property ((!ctl_reg[7] || ctl_reg[5:0] == 6'h00) |=> irq_out_n)
    else $error("pin low while gated off");
  chk_tx_pin_low: assert property ((ctl_reg[7] && ctl_reg[4] && tx0_irq_flag) |=> !irq_out_n)
    else $error("pin high with enabled tx0 request");
  chk_flags_global: assert property ((reg_rd && reg_addr == 8'h24 && (ctl_reg[5:4] & {tx1_irq_flag, tx0_irq_flag}) != 2'b00)
    |=> reg_rdata[7])
    else $error("global flag missing");
  chk_flags_tx: assert property ((reg_rd && reg_addr == 8'h24)
    |=> reg_rdata[6:4] == {1'b0, $past(tx1_irq_flag), $past(tx0_irq_flag)})
    else $error("top flags tx bits wrong");
  chk_ctl_read: assert property ((reg_rd && reg_addr == 8'h23) |=> reg_rdata == $past(ctl_reg))
    else $error("top control readback wrong");
  chk_port_num: assert property ((reg_rd && reg_addr == 8'h4D) |=> reg_rdata[7:6] == $past(sel_reg))
    else $error("port number field wrong");
  chk_unmapped_zero: assert property ((reg_rd && reg_addr == 8'h30) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule

bind hia_top hia_top_sva u_sva (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx0_irq_flag(tx0_irq_flag),
  .tx1_irq_flag(tx1_irq_flag), .irq_out_n(irq_out_n));

// ==== hia_top_tb_top.sv ====
// self-checking bench for the hub interrupt aggregator
`timescale 1ns/100ps
module hia_top_tb_top;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg [3:0] rx_lock = 4'h0, rx_pass = 4'h0, rx_lu = 4'h0, rx_fs = 4'h0, rx_nc = 4'h0;
  reg [31:0] ev = 32'h0;
  reg [15:0] fwd_gpio = 16'h0;
  reg [127:0] sensor_state = 128'h0;
  reg tx0 = 1'b0, tx1 = 1'b0, rd_taken = 1'b0;
  reg [31:0] seed = 32'h2, x;
  reg [7:0] exp_q[$];
  integer n_errors = 0, cmp_count = 0, i;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, irq_out_n;
  always #2.5 core_clk = ~core_clk;
  hia_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  hia_top uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_lock(rx_lock), .rx_pass(rx_pass), .rx_crc_err(ev[3:0]),
    .rx_seq_err(ev[7:4]), .rx_par_err(ev[11:8]), .rx_enc_err(ev[15:12]), .rx_buf_err(ev[19:16]),
    .rx_len_unstable(rx_lu), .rx_len_chg(ev[23:20]), .rx_cnt_chg(ev[27:24]), .rx_freq_stable(rx_fs),
    .rx_no_clk(rx_nc), .rx_tx_side_err(ev[31:28]), .fwd_gpio(fwd_gpio), .sensor_state(sensor_state),
    .tx0_irq_flag(tx0), .tx1_irq_flag(tx1), .irq_out_n(irq_out_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic [31:0] xs();
  begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  end
  endfunction
  task end_of_test;
  begin
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task cmp8(input string name, input [7:0] e, input [7:0] g);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    exp_q.push_back(e);
    host.rd(a);
  end
  endtask
  task pulse(input [31:0] m);
  begin
    @(negedge core_clk);
    ev = m;
    @(negedge core_clk);
    ev = 32'h0;
  end
  endtask
  // bounded wait; a pin that never arrives ends the run
  task wait_pin(input v);
  begin
    for (i = 0; i < 8 && irq_out_n !== v; i = i + 1)
      @(negedge core_clk);
    cmp8("irq_out_n", {7'h0, v}, {7'h0, irq_out_n});
    if (irq_out_n !== v)
      end_of_test;
  end
  endtask
  always @(posedge core_clk)
    rd_taken <= reg_rd;
  always @(negedge core_clk)
    if (rd_taken === 1'b1)
      cmp8("reg_rdata", exp_q.pop_front(), reg_rdata);
  initial
  begin
    #50000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    rd(8'h23, 8'h00);
    rd(8'h4C, 8'h01);
    rd(8'hD8, 8'h00);
    rd(8'hD9, 8'h00);
    host.wr(8'h24, 8'hFF);
    rd(8'h24, 8'h00);
    rd(8'h30, 8'h00);
    $display("test reset_values done");
    pulse(32'h1);
    rd(8'hDA, 8'h01);
    rd(8'hDA, 8'h01);
    rd(8'h4D, 8'h20);
    rd(8'hDA, 8'h00);
    host.wr(8'hD8, 8'h01);
    host.wr(8'h23, 8'h01);
    pulse(32'h1);
    rd(8'h24, 8'h81);
    repeat (4) @(negedge core_clk);
    cmp8("irq_out_n", 8'h01, {7'h0, irq_out_n});
    host.wr(8'h23, 8'h81);
    wait_pin(1'b0);
    rd(8'h4D, 8'h20);
    wait_pin(1'b1);
    $display("test pin_gating done");
    host.wr(8'h4C, 8'h24);
    x = xs();
    rx_lu[2] = x[0];
    rx_fs[2] = x[1];
    rx_nc[2] = x[2];
    rx_lock[2] = 1'b1;
    rx_pass[2] = 1'b1;
    pulse(32'h44444444);
    rd(8'hDB, 8'h7F);
    rd(8'hDA, 8'h07);
    rd(8'h4D, 8'hBF);
    rd(8'h4E, {x[0], 4'hF, x[1], x[2], 1'b1});
    rd(8'hDB, 8'h00);
    rd(8'hDA, 8'h00);
    $display("test port_state done");
    host.wr(8'h4C, 8'h01);
    host.wr(8'hE8, 8'hFF);
    x = xs() | 32'h1;
    sensor_state[31:0] = x;
    for (i = 0; i < 4; i = i + 1)
      rd(8'hE4 + i[7:0], x[8*i+:8]);
    rd(8'hDA, 8'h08);
    rd(8'hEB, 8'h00);
    rd(8'hEA, x[7:0]);
    rd(8'hEA, 8'h00);
    sensor_state[15:8] = ~x[15:8];
    rd(8'hEA, 8'h00);
    rd(8'hDA, 8'h00);
    host.wr(8'hE9, 8'hFF);
    sensor_state[7:0] = 8'h00;
    rd(8'hEA, 8'h00);
    rd(8'hDA, 8'h08);
    rd(8'hEB, x[7:0]);
    rd(8'hEB, 8'h00);
    pulse(32'h10000000);
    rd(8'hDB, 8'h08);
    rd(8'hE0, 8'h01);
    rd(8'hDB, 8'h00);
    $display("test sensor done");
    host.wr(8'hE1, 8'h01);
    fwd_gpio[0] = 1'b1;
    repeat (20) @(negedge core_clk);
    rd(8'hE2, 8'h01);
    rd(8'hE2, 8'h00);
    fwd_gpio[0] = 1'b0;
    repeat (20) @(negedge core_clk);
    rd(8'hE2, 8'h00);
    host.wr(8'hE1, 8'h10);
    fwd_gpio[0] = 1'b1;
    repeat (20) @(negedge core_clk);
    fwd_gpio[0] = 1'b0;
    repeat (20) @(negedge core_clk);
    rd(8'hDA, 8'h10);
    rd(8'hE2, 8'h10);
    rd(8'hE2, 8'h00);
    $display("test gpio done");
    host.wr(8'h23, 8'h90);
    tx0 = 1'b1;
    wait_pin(1'b0);
    rd(8'h24, 8'h90);
    tx0 = 1'b0;
    wait_pin(1'b1);
    tx1 = 1'b1;
    rd(8'h24, 8'h20);
    host.wr(8'h23, 8'hFF);
    rd(8'h23, 8'hBF);
    $display("test transmit done");
    repeat (3) @(negedge core_clk);
    end_of_test;
  end
endmodule
